/* rps_ctrl_model.sv */
// Controller model driving the panel's parallel RGB pins
`timescale 1ns/100ps
module rps_ctrl_model (
    // Bench clock that the pins are timed against
    input logic sys_clk,
    // Panel pins
    output logic pixel_clock,
    output logic hsync,
    output logic vsync,
    output logic line_valid_strobe,
    output logic [rps_pkg::CHAN_W-1:0] red_bits,
    output logic [rps_pkg::CHAN_W-1:0] green_bits,
    output logic [rps_pkg::CHAN_W-1:0] blue_bits
);
    initial begin
        {pixel_clock, hsync, vsync, line_valid_strobe} = 4'h0;
        {red_bits, green_bits, blue_bits} = 18'h0_0000;
    end
    // One line per call; clock idles low between lines.
    // Pins move only on bench clock edges, so no sample races them.
    task automatic send_line(input int len, input int strb, input bit vs,
            input logic [rps_pkg::PIX_W-1:0] base);
        for (int k = 0; k < len; k++) begin
            @(posedge sys_clk);
            hsync <= (k < 12);
            if (k == 1)
                vsync <= vs;
            // Strobe pulses once per line when strb > 0, never stuck high
            line_valid_strobe <= strb > 0 && k >= strb
                && k < strb + rps_pkg::H_ACTIVE;
            {red_bits, green_bits, blue_bits} <= base + 18'(k);
            // Data settles 20 ns before the rise, holds 60 ns after
            repeat (2) @(posedge sys_clk);
            // 80 ns period, faster than the panel's range, keeps runs
            // short; the receiver counts edges and never measures time
            pixel_clock <= 1'b1;
            repeat (4) @(posedge sys_clk);
            pixel_clock <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
endmodule

/* rps_panel_rx.sv */
// Panel-side receiver for the 18-bit parallel RGB input with sync decode
//
// What this block does
// - Pixel at strobe rise lands in leftmost column, rest go right.
// - Each line shows exactly 320 pixel clocks of data, rest discarded.
// - Strobe low for a whole line and the one before: first pixel taken 72 clocks after hsync edge.
// - First visible line taken 6 lines after vertical sync edge.
// - Each frame shows exactly 240 consecutive lines.
// - Strobe plays no part in vertical position.
// - Scan invert high flips image horizontally and vertically.
// - Three 6-bit channels, 0 darkest, form one 18-bit pixel.
`timescale 1ns/100ps
module rps_panel_rx (
    // System
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Panel input pins
    input wire logic pixel_clock,
    input wire logic hsync,
    input wire logic vsync,
    input wire logic line_valid_strobe,
    input wire logic scan_invert_select,
    input wire logic [rps_pkg::CHAN_W-1:0] red_bits,
    input wire logic [rps_pkg::CHAN_W-1:0] green_bits,
    input wire logic [rps_pkg::CHAN_W-1:0] blue_bits,
    // Pixel write towards the display array
    output logic pix_valid,
    output logic [rps_pkg::COL_W-1:0] pix_col,
    output logic [rps_pkg::ROW_W-1:0] pix_row,
    output logic [rps_pkg::CHAN_W-1:0] pix_red,
    output logic [rps_pkg::CHAN_W-1:0] pix_green,
    output logic [rps_pkg::CHAN_W-1:0] pix_blue
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [rps_pkg::SI_W-1:0] sync1_q;
    logic [rps_pkg::SI_W-1:0] sync2_q;
    logic pclk_prev_q;

    // Data and syncs share the clock's path delay, so the pixel
    // clock edge still sees settled data after two stages.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            pclk_prev_q <= 1'b0;
        end else begin
            sync1_q <= {pixel_clock, hsync, vsync, line_valid_strobe,
                        scan_invert_select, red_bits, green_bits, blue_bits};
            sync2_q <= sync1_q;
            pclk_prev_q <= sync2_q[rps_pkg::SI_PCLK];
        end
    end

    logic tick;
    logic hs_s;
    logic vs_s;
    logic strb_s;
    logic inv_s;
    logic [rps_pkg::PIX_W-1:0] rgb_s;
    assign tick = sync2_q[rps_pkg::SI_PCLK] & ~pclk_prev_q;
    assign hs_s = sync2_q[rps_pkg::SI_HS];
    assign vs_s = sync2_q[rps_pkg::SI_VS];
    assign strb_s = sync2_q[rps_pkg::SI_STRB];
    assign inv_s = sync2_q[rps_pkg::SI_INV];
    assign rgb_s = sync2_q[rps_pkg::PIX_W-1:0];

    // ------------------------------------------------------------
    // Edge detection in pixel clock time
    // ------------------------------------------------------------
    logic hs_prev_q;
    logic vs_prev_q;
    logic strb_prev_q;
    logic hs_edge;
    logic vs_edge;
    logic strb_rise;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            hs_prev_q <= 1'b0;
            vs_prev_q <= 1'b0;
            strb_prev_q <= 1'b0;
        end else if (tick) begin
            hs_prev_q <= hs_s;
            vs_prev_q <= vs_s;
            strb_prev_q <= strb_s;
        end
    end

    assign hs_edge = tick & hs_s & ~hs_prev_q;
    assign vs_edge = tick & vs_s & ~vs_prev_q;
    assign strb_rise = tick & strb_s & ~strb_prev_q;

    // ------------------------------------------------------------
    // Horizontal position
    // ------------------------------------------------------------
    logic [rps_pkg::HCNT_W-1:0] hcnt_q;
    logic strb_seen_q;
    logic strb_mode_q;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            hcnt_q <= '0;
        end else if (hs_edge) begin
            hcnt_q <= '0;
        end else if (tick && hcnt_q != rps_pkg::HCNT_MAX) begin
            hcnt_q <= hcnt_q + rps_pkg::HCNT_W'(1);
        end
    end

    // Mode is decided per line from the previous line, so only the first
    // strobe line after a strobe-less one also gets the fixed-offset start.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            strb_seen_q <= 1'b0;
            strb_mode_q <= 1'b0;
        end else if (hs_edge) begin
            strb_mode_q <= strb_seen_q | strb_s;
            strb_seen_q <= strb_s;
        end else if (tick && strb_s) begin
            strb_seen_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Vertical position
    // ------------------------------------------------------------
    logic [rps_pkg::VCNT_W-1:0] vline_q;
    logic row_ok;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            vline_q <= rps_pkg::VCNT_MAX;
        end else if (vs_edge) begin
            vline_q <= '0;
        end else if (hs_edge && vline_q != rps_pkg::VCNT_MAX) begin
            vline_q <= vline_q + rps_pkg::VCNT_W'(1);
        end
    end

    assign row_ok = (vline_q >= rps_pkg::V_FIRST)
                    && (vline_q < rps_pkg::V_END);

    // ------------------------------------------------------------
    // Pixel capture and placement
    // ------------------------------------------------------------
    logic start;
    logic active_q;
    logic [rps_pkg::COL_W-1:0] col_q;
    logic [rps_pkg::ROW_W-1:0] row_d;
    logic [rps_pkg::COL_W-1:0] col_d;
    logic take;

    assign start = row_ok && (strb_rise
        || (tick && !hs_edge && !strb_mode_q
            && hcnt_q == rps_pkg::HCNT_HIT));
    assign take = start
        || (tick && active_q && col_q != rps_pkg::COL_LAST);
    assign col_d = start ? '0 : col_q + rps_pkg::COL_W'(1);
    assign row_d = rps_pkg::ROW_W'(vline_q - rps_pkg::V_FIRST);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            active_q <= 1'b0;
            col_q <= '0;
        end else if (take) begin
            active_q <= 1'b1;
            col_q <= col_d;
        end else if (tick && active_q) begin
            active_q <= 1'b0;
        end
    end

    // Output words: one full pixel per pixel clock, mirrored if asked
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pix_valid <= 1'b0;
            pix_col <= '0;
            pix_row <= '0;
            pix_red <= '0;
            pix_green <= '0;
            pix_blue <= '0;
        end else begin
            pix_valid <= take;
            if (take) begin
                pix_col <= inv_s ? rps_pkg::COL_LAST - col_d
                                 : col_d;
                pix_row <= inv_s ? rps_pkg::ROW_LAST - row_d
                                 : row_d;
                {pix_red, pix_green, pix_blue} <= rgb_s;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_strobe_start;
        strb_rise && row_ok |=> pix_valid && col_q == '0;
    endproperty
    a_strobe_start: assert property (p_strobe_start)
        else $error("strobe edge did not start column zero");

    property p_fixed_start;
        tick && row_ok && !strb_mode_q && !hs_edge
            && hcnt_q == rps_pkg::HCNT_HIT |=> pix_valid && col_q == '0;
    endproperty
    a_fixed_start: assert property (p_fixed_start)
        else $error("fixed offset start missed");

    property p_line_len;
        tick && active_q && col_q == rps_pkg::COL_LAST && !start
            |=> !active_q && !pix_valid;
    endproperty
    a_line_len: assert property (p_line_len)
        else $error("line ran past its last column");

    property p_col_range;
        pix_valid |-> col_q <= rps_pkg::COL_LAST
            && pix_col <= rps_pkg::COL_LAST;
    endproperty
    a_col_range: assert property (p_col_range)
        else $error("column out of range");

    property p_vstart;
        vs_edge ##1 (!vs_edge && !hs_edge) [*1] |-> vline_q == '0;
    endproperty
    a_vstart: assert property (p_vstart)
        else $error("line count not restarted by vertical sync");

    property p_rows;
        pix_valid |-> pix_row <= rps_pkg::ROW_LAST
            && $past(vline_q) >= rps_pkg::V_FIRST;
    endproperty
    a_rows: assert property (p_rows)
        else $error("pixel written outside visible lines");

    property p_strobe_no_v;
        !hs_edge && !vs_edge |=> $stable(vline_q);
    endproperty
    a_strobe_no_v: assert property (p_strobe_no_v)
        else $error("line count moved without a sync edge");

    property p_invert;
        take && inv_s |=> pix_col == rps_pkg::COL_LAST - col_q;
    endproperty
    a_invert: assert property (p_invert)
        else $error("mirrored column wrong");

    property p_data;
        take |=> {pix_red, pix_green, pix_blue} == $past(rgb_s);
    endproperty
    a_data: assert property (p_data)
        else $error("pixel word not the sampled one");
endmodule

/* rps_pkg.sv */
// Constants for the parallel RGB panel input timing block
package rps_pkg;
    localparam int unsigned H_ACTIVE = 320;
    localparam int unsigned V_ACTIVE = 240;
    localparam int unsigned H_FIXED_START = 72;
    localparam int unsigned V_START = 6;
    localparam int unsigned CHAN_W = 6;
    localparam int unsigned PIX_W = 3 * CHAN_W;
    localparam int unsigned COL_W = 9;
    localparam int unsigned ROW_W = 8;
    localparam int unsigned HCNT_W = 10;
    localparam int unsigned VCNT_W = 9;
    localparam logic [COL_W-1:0] COL_LAST = COL_W'(H_ACTIVE - 1);
    localparam logic [ROW_W-1:0] ROW_LAST = ROW_W'(V_ACTIVE - 1);
    localparam logic [HCNT_W-1:0] HCNT_HIT = HCNT_W'(H_FIXED_START - 1);
    localparam logic [HCNT_W-1:0] HCNT_MAX = {HCNT_W{1'b1}};
    localparam logic [VCNT_W-1:0] VCNT_MAX = {VCNT_W{1'b1}};
    localparam logic [VCNT_W-1:0] V_FIRST = VCNT_W'(V_START);
    localparam logic [VCNT_W-1:0] V_END = VCNT_W'(V_START + V_ACTIVE);
    // Bit positions inside the synchronised input vector
    localparam int unsigned SI_PCLK = PIX_W + 4;
    localparam int unsigned SI_HS = PIX_W + 3;
    localparam int unsigned SI_VS = PIX_W + 2;
    localparam int unsigned SI_STRB = PIX_W + 1;
    localparam int unsigned SI_INV = PIX_W;
    localparam int unsigned SI_W = PIX_W + 5;
endpackage

/* tb.sv */
// Testbench for the panel receiver driven by the controller model
`timescale 1ns/100ps
module tb;
    logic sys_clk, sys_rst, scan_invert_select;
    logic pixel_clock, hsync, vsync, line_valid_strobe;
    logic [rps_pkg::CHAN_W-1:0] red_bits, green_bits, blue_bits;
    logic pix_valid;
    logic [rps_pkg::COL_W-1:0] pix_col;
    logic [rps_pkg::ROW_W-1:0] pix_row;
    logic [rps_pkg::CHAN_W-1:0] pix_red, pix_green, pix_blue;
    int num_errors = 0, n_tests = 0, cycles = 0, n_pix = 0;
    int e_start = 0, e_row = 0;
    logic [17:0] e_base = 18'h0_0000;

    rps_ctrl_model ctl_u (.sys_clk(sys_clk),
        .pixel_clock(pixel_clock), .hsync(hsync),
        .vsync(vsync), .line_valid_strobe(line_valid_strobe),
        .red_bits(red_bits), .green_bits(green_bits), .blue_bits(blue_bits));
    rps_panel_rx dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .pixel_clock(pixel_clock), .hsync(hsync), .vsync(vsync),
        .line_valid_strobe(line_valid_strobe),
        .scan_invert_select(scan_invert_select),
        .red_bits(red_bits), .green_bits(green_bits), .blue_bits(blue_bits),
        .pix_valid(pix_valid), .pix_col(pix_col), .pix_row(pix_row),
        .pix_red(pix_red), .pix_green(pix_green), .pix_blue(pix_blue));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic final_report();
        if (num_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Every pulse is judged against the column it should land in
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            num_errors++;
            $display("wrong value at %0t: timeout", $time);
            final_report();
        end
        if (pix_valid === 1'b1) begin
            n_tests++;
            if (pix_col !== (scan_invert_select ? rps_pkg::COL_LAST
                    - 9'(n_pix) : 9'(n_pix))
                || pix_row !== (scan_invert_select ? rps_pkg::ROW_LAST
                    - 8'(e_row) : 8'(e_row))
                || {pix_red, pix_green, pix_blue} !==
                    e_base + 18'(e_start + n_pix)) begin
                num_errors++;
                $display("wrong value at %0t: pixel %0d", $time, n_pix);
            end
            n_pix++;
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic run_line(input int len, input int strb, input bit vs,
            input int row, input int start, input int want);
        e_base = 18'(row * 1031 + strb + 5);
        e_row = row;
        e_start = start;
        n_pix = 0;
        ctl_u.send_line(len, strb, vs, e_base);
        repeat (10) @(posedge sys_clk);
        n_tests++;
        if (n_pix != want) begin
            num_errors++;
            $display("wrong value at %0t: %0d pixels", $time, n_pix);
        end
    endtask

    // Nothing shown before vsync or in the first six lines after it
    task automatic test_vstart();
        run_line(400, 0, 0, 0, 72, 0);
        run_line(16, 0, 1, 0, 72, 0);
        for (int i = 1; i < 5; i++)
            run_line(16, 0, 0, 0, 72, 0);
        run_line(400, 14, 0, 0, 14, 0);
    endtask

    // Strobe sets column zero at both offset limits, mirrored too
    task automatic test_strobe();
        run_line(400, 14, 0, 0, 14, 320);
        @(posedge sys_clk) scan_invert_select <= 1'b1;
        run_line(400, 72, 0, 1, 72, 320);
        @(posedge sys_clk) scan_invert_select <= 1'b0;
    endtask

    // Strobe held low: fixed start 72 clocks after hsync
    task automatic test_fixed();
        run_line(16, 0, 0, 0, 72, 0);
        run_line(400, 0, 0, 3, 72, 320);
    endtask

    // Last row shown mirrored, the line after it dropped.
    // Blank lines are short to keep the run brief; length is not checked.
    task automatic test_last_row();
        for (int i = 10; i < 245; i++)
            run_line(16, 0, 0, 0, 72, 0);
        @(posedge sys_clk) scan_invert_select <= 1'b1;
        run_line(400, 0, 0, 239, 72, 320);
        @(posedge sys_clk) scan_invert_select <= 1'b0;
        run_line(400, 0, 0, 0, 72, 0);
    endtask

    initial begin
        sys_rst = 1'b1;
        scan_invert_select = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        n_tests++;
        if (pix_valid !== 1'b0 || pix_col !== 9'h000) begin
            num_errors++;
            $display("wrong value at %0t: reset outputs", $time);
        end
        @(posedge sys_clk) sys_rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        test_vstart();
        test_strobe();
        test_fixed();
        test_last_row();
        final_report();
    end
endmodule
